/* rtl/acocr_pkg.sv */
// Constants for the clock and output configuration register bank
package acocr_pkg;
    // Serial frame layout: read flag, two spare bits, address, one data byte
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam logic [4:0] CNT_ADDR_LAST = 5'h0f;
    localparam logic [4:0] CNT_DATA_LAST = 5'h17;
    localparam int RD_FLAG_POS = 14;

    // Register offsets
    localparam logic [12:0] OFS_SKEW_DELTA = 13'h0070;
    localparam logic [12:0] OFS_CLK_RETARD = 13'h0071;
    localparam logic [12:0] OFS_CLK_RATIO = 13'h0072;
    localparam logic [12:0] OFS_DRV_FORMAT = 13'h0073;
    localparam logic [12:0] OFS_DLL_RANGE = 13'h0074;
    localparam logic [12:0] OFS_U0_CTRL_HI = 13'h00a4;
    localparam logic [12:0] OFS_U0_CTRL_LO = 13'h00a5;
    localparam logic [12:0] OFS_U0_STATE_HI = 13'h00a6;
    localparam logic [12:0] OFS_U0_STATE_LO = 13'h00a7;
    localparam logic [12:0] OFS_U1_CTRL_HI = 13'h00a8;
    localparam logic [12:0] OFS_U1_CTRL_LO = 13'h00a9;
    localparam logic [12:0] OFS_U1_STATE_HI = 13'h00aa;
    localparam logic [12:0] OFS_U1_STATE_LO = 13'h00ab;
    localparam logic [12:0] OFS_CAL_DONE = 13'h00b6;

    // Field positions
    localparam int SLIP_BIT = 0;
    localparam int RATIO_LSB = 0;
    localparam int DRV_LSB = 5;
    localparam int FMT_LSB = 0;
    localparam int DLL_RANGE_BIT = 6;
    localparam int CAL_DONE_BIT = 0;

    // Reset values
    localparam logic [7:0] RST_SKEW_DELTA = 8'h00;
    localparam logic RST_SLIP = 1'b0;
    localparam logic [2:0] RST_RATIO = 3'h0;
    localparam logic [2:0] RST_DRV = 3'h0;
    localparam logic [2:0] RST_FMT = 3'h0;
    localparam logic RST_DLL_RANGE = 1'b0;
    localparam logic [7:0] RST_DLL_CTRL = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // Clock ratio codes
    localparam logic [2:0] RATIO_PIN = 3'h0;
    localparam logic [2:0] RATIO_DIV1 = 3'h1;
    localparam logic [2:0] RATIO_DIV2 = 3'h2;

    // Output driver codes
    localparam logic [2:0] DRV_DIFF_3MA = 3'h0;
    localparam logic [2:0] DRV_DIFF_2MA = 3'h1;
    localparam logic [2:0] DRV_CMOS = 3'h4;

    // Sample number format codes
    localparam logic [2:0] FMT_TWOS = 3'h0;
    localparam logic [2:0] FMT_GRAY = 3'h2;
    localparam logic [2:0] FMT_OFFSET = 3'h4;

    // Serial frame states, Gray coded along the path
    typedef enum logic [1:0] {
        ACOCR_IDLE = 2'b00,
        ACOCR_INSTR = 2'b01,
        ACOCR_DATA = 2'b11,
        ACOCR_DONE = 2'b10
    } acocr_state_t;
endpackage

/* rtl/acocr_regs.sv */
// Clock, output and delay-lock configuration registers on a serial port
// Functional notes
// RL1 - Ratio code selects pin control, divide one/two
// RL2 - Driver field picks 3mA, 2mA or CMOS
// RL3 - Format field picks twos, Gray or offset
// RL4 - Slip bit moves sampling to next edge
// RL5 - Output registers survive soft reset, cleared otherwise
module acocr_regs #(
    parameter logic [7:0] U0_CTRL_HI_RST = 8'h00,
    parameter logic [7:0] U0_CTRL_LO_RST = 8'h00,
    parameter logic [7:0] U1_CTRL_HI_RST = 8'h00,
    parameter logic [7:0] U1_CTRL_LO_RST = 8'h00
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic soft_rst,
    // Serial port pins
    input wire logic csb_n,
    input wire logic sclk,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe_n,
    // Status from the converter core
    input wire logic [15:0] unit0_lock_state,
    input wire logic [15:0] unit1_lock_state,
    input wire logic cal_done,
    // Configuration towards the converter core
    output logic [7:0] skew_delta,
    output logic sample_slip,
    output logic ratio_pin_ctrl,
    output logic ratio_div1,
    output logic ratio_div2,
    output logic drv_low_current,
    output logic drv_cmos,
    output logic fmt_gray,
    output logic fmt_offset_bin,
    output logic dll_range_slow,
    output logic [15:0] unit0_lock_ctrl,
    output logic [15:0] unit1_lock_ctrl
);
    logic rst_m_r;
    logic rst_s_n;
    logic csb_s_n;
    logic sclk_s;
    logic sdi_s;
    logic sclk_d_r;
    acocr_pkg::acocr_state_t state_r;
    acocr_pkg::acocr_state_t state_nxt;
    logic [4:0] cnt_r;
    logic [22:0] shin_r;
    logic rd_r;
    logic [12:0] addr_r;
    logic [7:0] shout_r;
    logic [7:0] skew_r;
    logic slip_r;
    logic [2:0] ratio_r;
    logic [2:0] drv_r;
    logic [2:0] fmt_r;
    logic dll_range_r;
    logic [15:0] u0_ctrl_r;
    logic [15:0] u1_ctrl_r;

    // Reset release is synchronised so that every flop leaves reset together
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_m_r <= 1'b0;
            rst_s_n <= 1'b0;
        end else begin
            rst_m_r <= 1'b1;
            rst_s_n <= rst_m_r;
        end
    end

    // Pins cross into the clock domain; the port clock must stay well slower
    acocr_sync #(.W(3), .RST_VAL(3'b100)) u_pin_sync (
        .clk(clk),
        .rst_n(rst_s_n),
        .d({csb_n, sclk, sdi}),
        .q({csb_s_n, sclk_s, sdi_s})
    );

    // Edge and frame decode
    wire sclk_rise = sclk_s & ~sclk_d_r;
    wire sclk_fall = ~sclk_s & sclk_d_r;
    wire addr_last = sclk_rise && (cnt_r == acocr_pkg::CNT_ADDR_LAST);
    wire data_last = sclk_rise && (cnt_r == acocr_pkg::CNT_DATA_LAST);
    wire shift_out = sclk_fall && (cnt_r > acocr_pkg::CNT_ADDR_LAST + 5'h01);
    wire [12:0] cmd_addr = {shin_r[11:0], sdi_s};
    wire cmd_rd = shin_r[acocr_pkg::RD_FLAG_POS];
    wire [7:0] wdata = {shin_r[6:0], sdi_s};
    wire wr_en = data_last && !rd_r && (state_r == acocr_pkg::ACOCR_DATA);

    // Per-register write strobes
    wire wr_skew = wr_en && (addr_r == acocr_pkg::OFS_SKEW_DELTA);
    wire wr_slip = wr_en && (addr_r == acocr_pkg::OFS_CLK_RETARD);
    wire wr_ratio = wr_en && (addr_r == acocr_pkg::OFS_CLK_RATIO);
    wire wr_drvfmt = wr_en && (addr_r == acocr_pkg::OFS_DRV_FORMAT);
    wire wr_dll = wr_en && (addr_r == acocr_pkg::OFS_DLL_RANGE);
    wire wr_u0h = wr_en && (addr_r == acocr_pkg::OFS_U0_CTRL_HI);
    wire wr_u0l = wr_en && (addr_r == acocr_pkg::OFS_U0_CTRL_LO);
    wire wr_u1h = wr_en && (addr_r == acocr_pkg::OFS_U1_CTRL_HI);
    wire wr_u1l = wr_en && (addr_r == acocr_pkg::OFS_U1_CTRL_LO);

    // Frame sequencing; extra bits after one byte are ignored until CSB rises
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            acocr_pkg::ACOCR_IDLE: begin
                if (!csb_s_n) begin
                    state_nxt = acocr_pkg::ACOCR_INSTR;
                end
            end
            acocr_pkg::ACOCR_INSTR: begin
                if (addr_last) begin
                    state_nxt = acocr_pkg::ACOCR_DATA;
                end
            end
            acocr_pkg::ACOCR_DATA: begin
                if (data_last) begin
                    state_nxt = acocr_pkg::ACOCR_DONE;
                end
            end
            acocr_pkg::ACOCR_DONE: begin
                state_nxt = acocr_pkg::ACOCR_DONE;
            end
        endcase
        if (csb_s_n) begin
            state_nxt = acocr_pkg::ACOCR_IDLE;
        end
    end

    // Readback multiplexer; reserved bits and unmapped offsets read zero
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = acocr_pkg::RD_UNMAPPED;
        unique case (cmd_addr)
            acocr_pkg::OFS_SKEW_DELTA: rd_mux = skew_r;
            acocr_pkg::OFS_CLK_RETARD: rd_mux[acocr_pkg::SLIP_BIT] = slip_r;
            acocr_pkg::OFS_CLK_RATIO:
                rd_mux[acocr_pkg::RATIO_LSB +: 3] = ratio_r;
            acocr_pkg::OFS_DRV_FORMAT: begin
                rd_mux[acocr_pkg::DRV_LSB +: 3] = drv_r;
                rd_mux[acocr_pkg::FMT_LSB +: 3] = fmt_r;
            end
            acocr_pkg::OFS_DLL_RANGE:
                rd_mux[acocr_pkg::DLL_RANGE_BIT] = dll_range_r;
            acocr_pkg::OFS_U0_CTRL_HI: rd_mux = u0_ctrl_r[15:8];
            acocr_pkg::OFS_U0_CTRL_LO: rd_mux = u0_ctrl_r[7:0];
            acocr_pkg::OFS_U0_STATE_HI: rd_mux = unit0_lock_state[15:8];
            acocr_pkg::OFS_U0_STATE_LO: rd_mux = unit0_lock_state[7:0];
            acocr_pkg::OFS_U1_CTRL_HI: rd_mux = u1_ctrl_r[15:8];
            acocr_pkg::OFS_U1_CTRL_LO: rd_mux = u1_ctrl_r[7:0];
            acocr_pkg::OFS_U1_STATE_HI: rd_mux = unit1_lock_state[15:8];
            acocr_pkg::OFS_U1_STATE_LO: rd_mux = unit1_lock_state[7:0];
            acocr_pkg::OFS_CAL_DONE:
                rd_mux[acocr_pkg::CAL_DONE_BIT] = cal_done;
            default: rd_mux = acocr_pkg::RD_UNMAPPED;
        endcase
    end

    // Port shifter: capture on rising SCLK, drive read data on falling
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            state_r <= acocr_pkg::ACOCR_IDLE;
            sclk_d_r <= 1'b0;
            cnt_r <= 5'h00;
            shin_r <= 23'h000000;
            rd_r <= 1'b0;
            addr_r <= 13'h0000;
            shout_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            sclk_d_r <= sclk_s;
            if (csb_s_n) begin
                cnt_r <= 5'h00;
            end else if (sclk_rise && state_r != acocr_pkg::ACOCR_DONE) begin
                cnt_r <= cnt_r + 5'h01;
                shin_r <= {shin_r[21:0], sdi_s};
            end
            if (addr_last) begin
                addr_r <= cmd_addr;
                rd_r <= cmd_rd;
                shout_r <= rd_mux; // Read data sampled once per frame
            end else if (shift_out) begin
                shout_r <= {shout_r[6:0], 1'b0};
            end
        end
    end

    // Data output is enabled only during the data phase of a read
    assign sdo = shout_r[7];
    assign sdo_oe_n = !(rd_r && state_r == acocr_pkg::ACOCR_DATA);

    // Bank cleared by both full and soft reset
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            skew_r <= acocr_pkg::RST_SKEW_DELTA;
            slip_r <= acocr_pkg::RST_SLIP;
            ratio_r <= acocr_pkg::RST_RATIO;
            u0_ctrl_r <= {U0_CTRL_HI_RST, U0_CTRL_LO_RST};
            u1_ctrl_r <= {U1_CTRL_HI_RST, U1_CTRL_LO_RST};
        end else if (soft_rst) begin
            skew_r <= acocr_pkg::RST_SKEW_DELTA;
            slip_r <= acocr_pkg::RST_SLIP;
            ratio_r <= acocr_pkg::RST_RATIO;
            u0_ctrl_r <= {U0_CTRL_HI_RST, U0_CTRL_LO_RST};
            u1_ctrl_r <= {U1_CTRL_HI_RST, U1_CTRL_LO_RST};
        end else begin
            if (wr_skew) skew_r <= wdata;
            if (wr_slip) slip_r <= wdata[acocr_pkg::SLIP_BIT]; // RL4
            if (wr_ratio) ratio_r <= wdata[acocr_pkg::RATIO_LSB +: 3];
            if (wr_u0h) u0_ctrl_r[15:8] <= wdata;
            if (wr_u0l) u0_ctrl_r[7:0] <= wdata;
            if (wr_u1h) u1_ctrl_r[15:8] <= wdata;
            if (wr_u1l) u1_ctrl_r[7:0] <= wdata;
        end
    end

    // Output configuration ignores soft reset so the link stays up
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            drv_r <= acocr_pkg::RST_DRV; // RL5
            fmt_r <= acocr_pkg::RST_FMT;
            dll_range_r <= acocr_pkg::RST_DLL_RANGE;
        end else begin
            if (wr_drvfmt) begin
                drv_r <= wdata[acocr_pkg::DRV_LSB +: 3]; // RL2
                fmt_r <= wdata[acocr_pkg::FMT_LSB +: 3]; // RL3
            end
            if (wr_dll) dll_range_r <= wdata[acocr_pkg::DLL_RANGE_BIT];
        end
    end

    // Decoded controls; reserved ratio codes fall back to pin control
    wire dec_div1 = ratio_r == acocr_pkg::RATIO_DIV1; // RL1
    wire dec_div2 = ratio_r == acocr_pkg::RATIO_DIV2; // RL1
    wire dec_cmos = drv_r == acocr_pkg::DRV_CMOS; // RL2
    wire dec_2ma = drv_r == acocr_pkg::DRV_DIFF_2MA; // RL2
    wire dec_gray = fmt_r == acocr_pkg::FMT_GRAY; // RL3
    wire dec_offs = fmt_r == acocr_pkg::FMT_OFFSET; // RL3

    // Core-facing controls are registered to keep them glitch free
    always_ff @(posedge clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            skew_delta <= acocr_pkg::RST_SKEW_DELTA;
            sample_slip <= acocr_pkg::RST_SLIP;
            ratio_pin_ctrl <= 1'b1;
            ratio_div1 <= 1'b0;
            ratio_div2 <= 1'b0;
            drv_low_current <= 1'b0;
            drv_cmos <= 1'b0;
            fmt_gray <= 1'b0;
            fmt_offset_bin <= 1'b0;
            dll_range_slow <= acocr_pkg::RST_DLL_RANGE;
            unit0_lock_ctrl <= {U0_CTRL_HI_RST, U0_CTRL_LO_RST};
            unit1_lock_ctrl <= {U1_CTRL_HI_RST, U1_CTRL_LO_RST};
        end else begin
            skew_delta <= skew_r;
            sample_slip <= slip_r; // RL4
            ratio_pin_ctrl <= !(dec_div1 || dec_div2); // RL1
            ratio_div1 <= dec_div1;
            ratio_div2 <= dec_div2;
            drv_low_current <= dec_2ma;
            drv_cmos <= dec_cmos;
            fmt_gray <= dec_gray;
            fmt_offset_bin <= dec_offs;
            dll_range_slow <= dll_range_r;
            unit0_lock_ctrl <= u0_ctrl_r;
            unit1_lock_ctrl <= u1_ctrl_r;
        end
    end

    // Checks
    sequence s_fmt_write;
        wr_drvfmt && !soft_rst;
    endsequence

    AST_RATIO_DIV: assert property (@(posedge clk) // RL1
        disable iff (!rst_s_n)
        ratio_r == acocr_pkg::RATIO_DIV2 |=> ratio_div2 && !ratio_pin_ctrl
            && !ratio_div1)
        else $error("ratio code 010 not decoded to divide by two");
    AST_RATIO_PIN: assert property (@(posedge clk) // RL1
        disable iff (!rst_s_n)
        ratio_r == acocr_pkg::RATIO_PIN |=> ratio_pin_ctrl && !ratio_div2)
        else $error("ratio code 000 not decoded to pin control");
    AST_DRV_CMOS: assert property (@(posedge clk) // RL2
        disable iff (!rst_s_n)
        s_fmt_write ##1 (drv_r == acocr_pkg::DRV_CMOS) |=> drv_cmos
            && !drv_low_current)
        else $error("driver code 100 did not select CMOS");
    AST_DRV_DEF: assert property (@(posedge clk) // RL2
        disable iff (!rst_s_n)
        drv_r == acocr_pkg::DRV_DIFF_3MA |=> !drv_cmos && !drv_low_current)
        else $error("driver default not 3mA differential");
    AST_FMT_GRAY: assert property (@(posedge clk) // RL3
        disable iff (!rst_s_n)
        s_fmt_write ##1 (fmt_r == acocr_pkg::FMT_GRAY) |=> fmt_gray
            && !fmt_offset_bin)
        else $error("format code 010 did not select Gray");
    AST_SLIP: assert property (@(posedge clk) // RL4
        disable iff (!rst_s_n)
        wr_slip && !soft_rst |=> ##1 sample_slip == $past(wdata[0], 2))
        else $error("slip bit write did not reach output");
    AST_SOFT_KEEP: assert property (@(posedge clk) // RL5
        disable iff (!rst_s_n)
        soft_rst && !wr_drvfmt && !wr_dll |=> drv_r == $past(drv_r)
            && fmt_r == $past(fmt_r) && dll_range_r == $past(dll_range_r))
        else $error("soft reset disturbed output configuration");
    AST_SOFT_CLR: assert property (@(posedge clk) // RL5
        disable iff (!rst_s_n)
        soft_rst |=> ratio_r == acocr_pkg::RST_RATIO && !slip_r ##1
            ratio_pin_ctrl)
        else $error("soft reset did not clear clock controls");
endmodule

/* rtl/acocr_sync.sv */
// Two flip-flop synchroniser for pins entering the device clock
module acocr_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Asynchronous input and synchronised copy
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

/* test/acocr_host_model.sv */
// Serial host model that drives frames on the configuration port
module acocr_host_model #(
    parameter int HALF = 6,
    parameter int GAP = 6
) (
    // Device clock
    input wire logic clk,
    // Serial port pins
    output logic csb_n,
    output logic sclk,
    output logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle levels: deselected, serial clock parked low between frames
    initial begin
        csb_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end

    // One frame; nbits below 24 abandons it early. Half periods of six
    // device clocks leave room for the two-flop pin synchronisers.
    task automatic frame(input logic rd, input logic [12:0] addr,
        input logic [7:0] wdata, input int nbits,
        output logic [7:0] rdata, output logic oe_bad);
        logic [23:0] bits;
        bits = {rd, 2'b00, addr, wdata};
        rdata = 8'h00;
        oe_bad = 1'b0;
        csb_n <= 1'b0;
        repeat (HALF) @(posedge clk);
        for (int i = 0; i < nbits; i++) begin
            sdi <= bits[23 - i];
            repeat (HALF) @(posedge clk);
            if (i >= 16) begin
                rdata = {rdata[6:0], sdo};
                oe_bad = oe_bad | (sdo_oe_n !== !rd);
            end
            sclk <= 1'b1;
            repeat (HALF) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (HALF) @(posedge clk);
        csb_n <= 1'b1;
        sdi <= ~sdi; // Released line must not keep showing the last bit
        repeat (GAP) @(posedge clk);
    endtask
endmodule

/* test/tb_top.sv */
// Testbench for the clock and output configuration register bank
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, rst_n, soft_rst, cal_done;
    logic [15:0] unit0_lock_state, unit1_lock_state;
    logic csb_n, sclk, sdi, sdo, sdo_oe_n, sample_slip, dll_range_slow;
    logic ratio_pin_ctrl, ratio_div1, ratio_div2, drv_low_current;
    logic drv_cmos, fmt_gray, fmt_offset_bin;
    logic [7:0] skew_delta;
    logic [15:0] unit0_lock_ctrl, unit1_lock_ctrl;
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;

    acocr_host_model host (.clk(clk), .csb_n(csb_n), .sclk(sclk),
        .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n));

    acocr_regs dut (.clk(clk), .rst_n(rst_n), .soft_rst(soft_rst),
        .csb_n(csb_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
        .sdo_oe_n(sdo_oe_n), .unit0_lock_state(unit0_lock_state),
        .unit1_lock_state(unit1_lock_state), .cal_done(cal_done),
        .skew_delta(skew_delta), .sample_slip(sample_slip),
        .ratio_pin_ctrl(ratio_pin_ctrl), .ratio_div1(ratio_div1),
        .ratio_div2(ratio_div2), .drv_low_current(drv_low_current),
        .drv_cmos(drv_cmos), .fmt_gray(fmt_gray),
        .fmt_offset_bin(fmt_offset_bin), .dll_range_slow(dll_range_slow),
        .unit0_lock_ctrl(unit0_lock_ctrl), .unit1_lock_ctrl(unit1_lock_ctrl));

    // 25 MHz device clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Case equality so an unknown never counts as a match
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Write frame; sdo must stay released during the data bits
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] q;
        logic bad;
        host.frame(1'b0, a, d, 24, q, bad);
        check({15'h0000, bad}, 16'h0000);
    endtask

    // Read frame; compares the byte and the drive enable together
    task automatic rd(input logic [12:0] a, input logic [7:0] e);
        logic [7:0] q;
        logic bad;
        host.frame(1'b1, a, 8'h00, 24, q, bad);
        check({7'h00, bad, q}, {8'h00, e});
    endtask

    task automatic full_reset;
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk); // Pin synchronisers settle first
    endtask

    // Cycle ceiling: about 129 frames of roughly 310 clocks each
    initial begin
        forever @(posedge clk) begin
            cycles++;
            if (cycles == 40000) begin
                mismatches++;
                $display("timeout after %0d cycles", cycles);
                complete_run();
            end
        end
    end

    initial begin
        logic [7:0] q;
        logic bad;
        logic [2:0] c;
        rst_n = 1'b0;
        soft_rst = 1'b0;
        cal_done = 1'b0;
        unit0_lock_state = 16'h0000;
        unit1_lock_state = 16'h0000;
        @(posedge clk);
        full_reset();
        check({skew_delta, sample_slip, ratio_pin_ctrl, ratio_div1,
            ratio_div2, drv_low_current, drv_cmos, fmt_gray,
            fmt_offset_bin}, 16'h0040);
        check({15'h0000, dll_range_slow}, 16'h0000);
        check(unit0_lock_ctrl | unit1_lock_ctrl, 16'h0000);
        for (int a = 'h70; a <= 'h74; a++) rd(13'(a), 8'h00);
        $display("test reset values done");

        // Every ratio code, reserved ones fall back to pin control
        for (int i = 0; i < 8; i++) begin
            wr(13'h0072, 8'(i));
            check({13'h0000, ratio_pin_ctrl, ratio_div1, ratio_div2},
                {13'h0000, i != 1 && i != 2, i == 1, i == 2});
            rd(13'h0072, 8'(i));
        end
        $display("test clock ratio done");

        // Every driver and format code, reserved ones decode to defaults
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            wr(13'h0073, {c, 2'b00, c});
            check({12'h000, drv_low_current, drv_cmos, fmt_gray,
                fmt_offset_bin}, {12'h000, c == 3'h1, c == 3'h4, c == 3'h2,
                c == 3'h4});
            rd(13'h0073, {c, 2'b00, c});
        end
        $display("test output mode done");

        wr(13'h0071, 8'hff);
        check({15'h0000, sample_slip}, 16'h0001);
        rd(13'h0071, 8'h01);
        wr(13'h0071, 8'h00);
        check({15'h0000, sample_slip}, 16'h0000);
        $display("test clock slip done");

        // Status words, control words, read-only and unmapped places
        unit0_lock_state <= 16'h1234;
        unit1_lock_state <= 16'hbeef;
        cal_done <= 1'b1;
        wr(13'h0070, 8'ha5);
        wr(13'h00a4, 8'hc3);
        wr(13'h00a5, 8'h3c);
        wr(13'h00a8, 8'h96);
        wr(13'h00a9, 8'h69);
        check({8'h00, skew_delta}, 16'h00a5);
        check(unit0_lock_ctrl, 16'hc33c);
        check(unit1_lock_ctrl, 16'h9669);
        rd(13'h00a6, 8'h12);
        rd(13'h00a7, 8'h34);
        rd(13'h00aa, 8'hbe);
        rd(13'h00ab, 8'hef);
        rd(13'h00b6, 8'h01);
        wr(13'h00a6, 8'hff);
        rd(13'h00a6, 8'h12);
        rd(13'h0075, 8'h00);
        host.frame(1'b0, 13'h0070, 8'h11, 20, q, bad);
        check({8'h00, skew_delta}, 16'h00a5);
        $display("test map and status done");

        // Soft reset keeps the output registers, full reset clears them
        wr(13'h0073, 8'h84);
        wr(13'h0074, 8'hff);
        wr(13'h0071, 8'h01);
        wr(13'h0072, 8'h01);
        soft_rst <= 1'b1;
        @(posedge clk);
        soft_rst <= 1'b0;
        repeat (3) @(posedge clk);
        check({skew_delta, ratio_pin_ctrl, drv_cmos, fmt_offset_bin,
            dll_range_slow, sample_slip, ratio_div1, 2'b00}, 16'h00f0);
        check(unit0_lock_ctrl | unit1_lock_ctrl, 16'h0000);
        rd(13'h0073, 8'h84);
        rd(13'h0074, 8'h40);
        full_reset();
        check({13'h0000, drv_cmos, fmt_offset_bin, dll_range_slow},
            16'h0000);
        rd(13'h0073, 8'h00);
        rd(13'h0074, 8'h00);
        $display("test soft reset done");
        complete_run();
    end
endmodule
